/* File: pmr_mode_ctrl.sv */
// Operating-mode controller with the retained register set.
// Assumes supply source, metering power-down and wake inputs are synchronous.
`timescale 1ns/100ps
module pmr_mode_ctrl
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port from the core
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Supply and system status
	input wire logic switched_rail_on_main_i,
	input wire logic metering_power_down_i,
	input wire logic wake_event_i,
	input wire logic soft_reset_i,
	// Domain controls
	output logic internal_digital_rail_en_o,
	output logic internal_analog_rail_en_o,
	output logic metering_analog_en_o,
	output logic peripherals_3v3_en_o,
	output logic core_reset_vector_o,
	output logic [2:0] core_clock_div_o,
	output logic [1:0] mode_o
);

	pmr_mode_t mode;
	pmr_mode_t next_mode;
	logic [7:0] power_control;
	logic ret_hit;
	logic [7:0] ret_rdata;
	logic sleep_req;
	logic sleep_exit;
	logic pc_sel;

	assign pc_sel = (reg_addr_i == ADDR_POWER_CONTROL_REG);
	assign sleep_req = reg_wr_i && pc_sel && reg_wdata_i[POWER_CONTROL_SLEEP_BIT];

	// ----------------------------------------
	// Retained registers
	// ----------------------------------------
	pmr_retention_file u_ret (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(reg_wr_i && mode != PMR_SLEEP_MODE),
		.addr_i(reg_addr_i),
		.wdata_i(reg_wdata_i),
		.hit_o(ret_hit),
		.rdata_o(ret_rdata)
	);

	// ----------------------------------------
	// Mode state
	// ----------------------------------------
	always_comb begin
		next_mode = mode;
		case (mode)
			PMR_NORMAL_MODE: begin
				if (!switched_rail_on_main_i) begin
					next_mode = PMR_BATTERY_MODE;
				end
			end
			PMR_BATTERY_MODE: begin
				if (switched_rail_on_main_i && !metering_power_down_i) begin
					next_mode = PMR_NORMAL_MODE;
				end else if (sleep_req) begin
					next_mode = PMR_SLEEP_MODE;
				end
			end
			PMR_SLEEP_MODE: begin
				if (switched_rail_on_main_i && !metering_power_down_i) begin
					next_mode = PMR_NORMAL_MODE;
				end else if (wake_event_i) begin
					next_mode = PMR_BATTERY_MODE;
				end
			end
			default: begin
				next_mode = PMR_NORMAL_MODE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= PMR_NORMAL_MODE;
		end else begin
			mode <= next_mode;
		end
	end

	assign sleep_exit = (mode == PMR_SLEEP_MODE) && (next_mode != PMR_SLEEP_MODE);

	// ----------------------------------------
	// Power control register
	// ----------------------------------------
	// Sleep bit self-clears so a wake does not re-enter sleep at once
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_control <= POWER_CONTROL_RESET;
		end else if (soft_reset_i || sleep_exit) begin
			power_control <= POWER_CONTROL_RESET;
		end else if (reg_wr_i && pc_sel && mode != PMR_SLEEP_MODE) begin
			power_control <= reg_wdata_i & ~(8'h01 << POWER_CONTROL_SLEEP_BIT);
		end
	end

	// ----------------------------------------
	// Domain enables
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			internal_digital_rail_en_o <= 1'b1;
			internal_analog_rail_en_o <= 1'b1;
			metering_analog_en_o <= 1'b1;
			peripherals_3v3_en_o <= 1'b1;
		end else begin
			case (next_mode)
				PMR_NORMAL_MODE: begin
					internal_digital_rail_en_o <= 1'b1;
					internal_analog_rail_en_o <= 1'b1;
					metering_analog_en_o <= 1'b1;
				end
				PMR_BATTERY_MODE: begin
					internal_digital_rail_en_o <= 1'b1;
					internal_analog_rail_en_o <= 1'b1;
					metering_analog_en_o <= 1'b0;
				end
				default: begin
					internal_digital_rail_en_o <= 1'b0;
					internal_analog_rail_en_o <= 1'b0;
					metering_analog_en_o <= 1'b0;
				end
			endcase
			peripherals_3v3_en_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Core restart and clock
	// ----------------------------------------
	// Held through sleep and released one cycle after the exit, so
	// the core can only start from the reset vector
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_reset_vector_o <= 1'b1;
		end else begin
			core_reset_vector_o <= (next_mode == PMR_SLEEP_MODE) || sleep_exit;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_clock_div_o <= CORE_CLOCK_DEFAULT_DIV;
			mode_o <= PMR_NORMAL_MODE;
		end else begin
			core_clock_div_o <= (soft_reset_i || sleep_exit) ? CORE_CLOCK_DEFAULT_DIV :
				power_control[POWER_CONTROL_CLKDIV_LSB +: POWER_CONTROL_CLKDIV_W];
			mode_o <= next_mode;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped addresses read zero; source bit reflects the rail
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			if (pc_sel) begin
				reg_rdata_o <= power_control;
			end else if (reg_addr_i == ADDR_PERIPHERAL_CONFIG) begin
				reg_rdata_o <= (ret_rdata & ~(8'h01 << PERIPHERAL_SOURCE_BIT)) |
					({7'h00, switched_rail_on_main_i} << PERIPHERAL_SOURCE_BIT);
			end else if (ret_hit) begin
				reg_rdata_o <= ret_rdata;
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

endmodule : pmr_mode_ctrl

/* File: pmr_mode_ctrl_tb.sv */
// Self-checking bench of the mode controller with random supply changes.
// Assumes the package, design and monitor are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module pmr_mode_ctrl_tb
	import pmr_pkg::*;
;
	logic clk_sys_i = 0, rst_n_i = 0, reg_wr = 0, reg_rd = 0;
	logic rail = 1, pd = 0, wake = 0, srst = 0;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic [7:0] exp_r [NUM_RETAINED];
	logic dig, ana, met, p33, rv;
	logic [2:0] div;
	logic [1:0] mode, em = 2'b00;
	int err_count = 0;
	int cmp_count = 0;

	pmr_mode_ctrl i_dut (
		.clk_sys_i, .rst_n_i, .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .switched_rail_on_main_i(rail),
		.metering_power_down_i(pd), .wake_event_i(wake), .soft_reset_i(srst),
		.internal_digital_rail_en_o(dig), .internal_analog_rail_en_o(ana),
		.metering_analog_en_o(met), .peripherals_3v3_en_o(p33),
		.core_reset_vector_o(rv), .core_clock_div_o(div), .mode_o(mode)
	);

	initial forever #2 clk_sys_i = ~clk_sys_i;

	// ----
	// Expectations and bus tasks
	// ----
	// Sleep is never predicted here: only supply moves are randomised
	function automatic logic [1:0] nxt(logic [1:0] m, logic r, logic p);
		if (m == 2'b00)
			return r ? 2'b00 : 2'b01;
		return (r && !p) ? 2'b00 : 2'b01;
	endfunction : nxt
	function automatic logic [3:0] outs(logic [1:0] m);
		return {m != 2'b11, m != 2'b11, m == 2'b00, 1'b1};
	endfunction : outs
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick
	task automatic chk_mode(logic [1:0] m, logic r);
		`CHK(mode, m)
		`CHK({dig, ana, met, p33}, outs(m))
		`CHK(rv, r)
	endtask : chk_mode
	// Each access ends with an idle edge, so chained calls never retoggle a strobe
	task automatic write_reg(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		reg_wr = 1;
		tick();
		reg_wr = 0;
		tick();
	endtask : write_reg
	task automatic read_reg(logic [7:0] a, logic [7:0] e);
		addr = a;
		reg_rd = 1;
		tick();
		reg_rd = 0;
		`CHK(rdata, e)
		tick();
	endtask : read_reg
	// The rail source bit reads live, everything else as stored
	function automatic logic [7:0] rd_exp(int i);
		logic [7:0] v;
		v = exp_r[i];
		if (RETAINED_ADDR[i] == ADDR_PERIPHERAL_CONFIG)
			v[PERIPHERAL_SOURCE_BIT] = rail;
		return v;
	endfunction : rd_exp
	task automatic read_all;
		foreach (exp_r[i])
			read_reg(RETAINED_ADDR[i], rd_exp(i));
	endtask : read_all
	task automatic go_sleep;
		rail = 0;
		pd = 0;
		tick();
		write_reg(ADDR_POWER_CONTROL_REG, 8'h10);
		chk_mode(2'b11, 1'b1);
	endtask : go_sleep
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hF7FEE04C));
		tick(16);
		chk_mode(2'b00, 1'b1);
		`CHK(div, CORE_CLOCK_DEFAULT_DIV)
		rst_n_i = 1;
		tick();
		chk_mode(2'b00, 1'b0);
		foreach (exp_r[i]) begin
			exp_r[i] = RETAINED_RESET;
			read_reg(RETAINED_ADDR[i], rd_exp(i));
			exp_r[i] = 8'($urandom);
			write_reg(RETAINED_ADDR[i], exp_r[i]);
		end
		read_all();
		read_reg(8'h00, 8'h00);
		write_reg(ADDR_POWER_CONTROL_REG, 8'h05);
		`CHK(div, 3'h5)
		read_reg(ADDR_POWER_CONTROL_REG, 8'h05);
		srst = 1;
		tick();
		srst = 0;
		`CHK(div, CORE_CLOCK_DEFAULT_DIV)
		read_reg(ADDR_POWER_CONTROL_REG, POWER_CONTROL_RESET);
		repeat (60) begin
			{rail, pd} = 2'($urandom);
			em = nxt(em, rail, pd);
			tick();
			chk_mode(em, 1'b0);
		end
		go_sleep();
		write_reg(ADDR_RETAINED_PAD_1, ~exp_r[21]);
		tick(20);
		chk_mode(2'b11, 1'b1);
		wake = 1;
		tick();
		wake = 0;
		chk_mode(2'b01, 1'b1);
		`CHK(div, CORE_CLOCK_DEFAULT_DIV)
		tick();
		chk_mode(2'b01, 1'b0);
		read_all();
		// Software brings back the clock setting that sleep did not keep
		write_reg(ADDR_POWER_CONTROL_REG, 8'h03);
		`CHK(div, 3'h3)
		go_sleep();
		{rail, pd, wake} = 3'b101;
		tick();
		chk_mode(2'b00, 1'b1);
		`CHK(div, CORE_CLOCK_DEFAULT_DIV)
		wake = 0;
		tick();
		chk_mode(2'b00, 1'b0);
		rst_n_i = 0;
		tick();
		chk_mode(2'b00, 1'b1);
		`CHK(rdata, 8'h00)
		rst_n_i = 1;
		tick();
		chk_mode(2'b00, 1'b0);
		read_reg(ADDR_RETAINED_PAD_1, RETAINED_RESET);
		report_and_stop();
	end
endmodule : pmr_mode_ctrl_tb

/* File: pmr_monitor.sv */
// Port checker for the mode controller.
// Assumes it is bound to pmr_mode_ctrl, one clock domain.
`timescale 1ns/100ps
module pmr_monitor
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Watched inputs
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic switched_rail_on_main_i,
	input wire logic metering_power_down_i,
	input wire logic wake_event_i,
	input wire logic soft_reset_i,
	// Watched outputs
	input wire logic internal_digital_rail_en_o,
	input wire logic internal_analog_rail_en_o,
	input wire logic metering_analog_en_o,
	input wire logic peripherals_3v3_en_o,
	input wire logic core_reset_vector_o,
	input wire logic [2:0] core_clock_div_o,
	input wire logic [1:0] mode_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Main back and metering allowed up
	wire ret = switched_rail_on_main_i && !metering_power_down_i;
	wire slp = reg_wr_i && reg_addr_i == ADDR_POWER_CONTROL_REG &&
		reg_wdata_i[POWER_CONTROL_SLEEP_BIT];
	wire up = mode_o != PMR_SLEEP_MODE;
	// Wake holds the core one cycle at the vector, then lets it run
	sequence s_woke;
		mode_o == PMR_BATTERY_MODE && core_reset_vector_o ##1 !core_reset_vector_o;
	endsequence
	property p_sleep;
		mode_o == PMR_BATTERY_MODE && slp && !ret && !soft_reset_i |=>
			mode_o == PMR_SLEEP_MODE && !internal_digital_rail_en_o && core_reset_vector_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry");
	property p_rails;
		internal_digital_rail_en_o == up && internal_analog_rail_en_o == up && peripherals_3v3_en_o;
	endproperty
	a_rails: assert property (p_rails) else $error("rail enables");
	property p_meter;
		metering_analog_en_o == (mode_o == PMR_NORMAL_MODE);
	endproperty
	a_meter: assert property (p_meter) else $error("metering enable");
	property p_wake;
		mode_o == PMR_SLEEP_MODE && wake_event_i && !ret |=> s_woke;
	endproperty
	a_wake: assert property (p_wake) else $error("wake exit");
	property p_hold;
		mode_o == PMR_SLEEP_MODE && !wake_event_i && !ret |=> mode_o == PMR_SLEEP_MODE;
	endproperty
	a_hold: assert property (p_hold) else $error("sleep left");
	property p_back;
		mode_o == PMR_BATTERY_MODE && ret && !reg_wr_i |=>
			mode_o == PMR_NORMAL_MODE && !core_reset_vector_o;
	endproperty
	a_back: assert property (p_back) else $error("battery return");
	property p_drop;
		mode_o == PMR_NORMAL_MODE && !switched_rail_on_main_i |=> mode_o == PMR_BATTERY_MODE;
	endproperty
	a_drop: assert property (p_drop) else $error("switchover");
	property p_exit;
		mode_o == PMR_SLEEP_MODE && ret |=> mode_o == PMR_NORMAL_MODE && core_reset_vector_o;
	endproperty
	a_exit: assert property (p_exit) else $error("sleep to normal");
	property p_soft;
		soft_reset_i && !reg_wr_i |=> core_clock_div_o == CORE_CLOCK_DEFAULT_DIV;
	endproperty
	a_soft: assert property (p_soft) else $error("clock default");
endmodule : pmr_monitor

bind pmr_mode_ctrl pmr_monitor i_mon (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_addr_i,
	.reg_wdata_i, .switched_rail_on_main_i, .metering_power_down_i, .wake_event_i,
	.soft_reset_i, .internal_digital_rail_en_o, .internal_analog_rail_en_o,
	.metering_analog_en_o, .peripherals_3v3_en_o, .core_reset_vector_o,
	.core_clock_div_o, .mode_o);

/* File: pmr_pkg.sv */
// Package for the operating-mode and retention controller.
// Assumes an 8-bit special function register space addressed by 8 bits.
package pmr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_DISPLAY_CONFIG = 8'h95;
	localparam logic [7:0] ADDR_DISPLAY_CLOCK = 8'h96;
	localparam logic [7:0] ADDR_DISPLAY_SEGMENT_ENABLE = 8'h97;
	localparam logic [7:0] ADDR_DISPLAY_CONFIG_X = 8'h9C;
	localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'hA1;
	localparam logic [7:0] ADDR_HUNDREDTHS_COUNT = 8'hA2;
	localparam logic [7:0] ADDR_SECONDS_COUNT = 8'hA3;
	localparam logic [7:0] ADDR_MINUTES_COUNT = 8'hA4;
	localparam logic [7:0] ADDR_HOURS_COUNT = 8'hA5;
	localparam logic [7:0] ADDR_ALARM_INTERVAL = 8'hA6;
	localparam logic [7:0] ADDR_DISPLAY_POINTER = 8'hAC;
	localparam logic [7:0] ADDR_DISPLAY_DATA = 8'hAE;
	localparam logic [7:0] ADDR_DISPLAY_CONFIG_Y = 8'hB1;
	localparam logic [7:0] ADDR_PORT0_PULLUP_ENABLE = 8'hB2;
	localparam logic [7:0] ADDR_PORT1_PULLUP_ENABLE = 8'hB3;
	localparam logic [7:0] ADDR_PORT2_PULLUP_ENABLE = 8'hB4;
	localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'hC5;
	localparam logic [7:0] ADDR_DISPLAY_SEGMENT_ENABLE_2 = 8'hED;
	localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hF4;
	localparam logic [7:0] ADDR_SWITCHOVER_CONFIG = 8'hF5;
	localparam logic [7:0] ADDR_CLOCK_NOMINAL_COMP = 8'hF6;
	localparam logic [7:0] ADDR_CLOCK_TEMPERATURE_COMP = 8'hF7;
	localparam logic [7:0] ADDR_RETAINED_PAD_1 = 8'hFB;
	localparam logic [7:0] ADDR_RETAINED_PAD_2 = 8'hFC;
	localparam logic [7:0] ADDR_RETAINED_PAD_3 = 8'hFD;
	localparam logic [7:0] ADDR_RETAINED_PAD_4 = 8'hFE;
	localparam logic [7:0] ADDR_INTERRUPT_PIN_CONFIG = 8'hFF;

	// ----------------------------------------
	// Retained register file layout
	// ----------------------------------------
	localparam int NUM_RETAINED = 26;
	localparam logic [7:0] RETAINED_RESET = 8'h00;
	localparam logic [7:0] RETAINED_ADDR [NUM_RETAINED] = '{
		ADDR_DISPLAY_CONFIG, ADDR_DISPLAY_CLOCK, ADDR_DISPLAY_SEGMENT_ENABLE,
		ADDR_DISPLAY_CONFIG_X, ADDR_CLOCK_CONFIG, ADDR_HUNDREDTHS_COUNT,
		ADDR_SECONDS_COUNT, ADDR_MINUTES_COUNT, ADDR_HOURS_COUNT,
		ADDR_ALARM_INTERVAL, ADDR_DISPLAY_POINTER, ADDR_DISPLAY_DATA,
		ADDR_DISPLAY_CONFIG_Y, ADDR_PORT0_PULLUP_ENABLE, ADDR_PORT1_PULLUP_ENABLE,
		ADDR_PORT2_PULLUP_ENABLE, ADDR_DISPLAY_SEGMENT_ENABLE_2, ADDR_PERIPHERAL_CONFIG,
		ADDR_SWITCHOVER_CONFIG, ADDR_CLOCK_NOMINAL_COMP, ADDR_CLOCK_TEMPERATURE_COMP,
		ADDR_RETAINED_PAD_1, ADDR_RETAINED_PAD_2, ADDR_RETAINED_PAD_3,
		ADDR_RETAINED_PAD_4, ADDR_INTERRUPT_PIN_CONFIG
	};

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int POWER_CONTROL_SLEEP_BIT = 4;
	localparam int POWER_CONTROL_CLKDIV_LSB = 0;
	localparam int POWER_CONTROL_CLKDIV_W = 3;
	localparam int PERIPHERAL_SOURCE_BIT = 6;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h02;
	// Divider code 2 selects the 1.024 MHz core clock
	localparam logic [2:0] CORE_CLOCK_DEFAULT_DIV = 3'h2;
	localparam int CORE_CLOCK_DEFAULT_KHZ = 1024;

	// ----------------------------------------
	// Operating modes, Gray along normal-battery-sleep
	// ----------------------------------------
	typedef enum logic [1:0] {
		PMR_NORMAL_MODE = 2'b00,
		PMR_BATTERY_MODE = 2'b01,
		PMR_SLEEP_MODE = 2'b11
	} pmr_mode_t;

endpackage : pmr_pkg

/* File: pmr_retention_file.sv */
// Register array that keeps its contents through sleep.
// Assumes the caller supplies one write strobe; hits are decoded here from the address.
`timescale 1ns/100ps
module pmr_retention_file
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Access
	input wire logic wr_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	// Read side
	output logic hit_o,
	output logic [7:0] rdata_o
);

	logic [7:0] store [NUM_RETAINED];
	logic [NUM_RETAINED-1:0] match;

	// ----------------------------------------
	// Storage, untouched by sleep entry and exit
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_RETAINED; g++) begin : g_reg
			assign match[g] = (addr_i == RETAINED_ADDR[g]);
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					store[g] <= RETAINED_RESET;
				end else if (wr_en_i && match[g]) begin
					store[g] <= wdata_i;
				end
			end
		end
	endgenerate

	always_comb begin
		hit_o = |match;
		rdata_o = 8'h00;
		for (int i = 0; i < NUM_RETAINED; i++) begin
			if (match[i]) begin
				rdata_o = store[i];
			end
		end
	end

endmodule : pmr_retention_file
